//--- rtl/acb_pkg.sv
package acb_pkg;
   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_COMMAND = 8'h00; // command opcode, write only
   localparam logic [7:0] OFS_DEVHEAD = 8'h04; // device/head select
   localparam logic [7:0] OFS_ADDR_HI = 8'h08; // address bits 23..16
   localparam logic [7:0] OFS_ADDR_MID = 8'h0c; // address bits 15..8
   localparam logic [7:0] OFS_ADDR_LO = 8'h10; // address bits 7..0
   localparam logic [7:0] OFS_COUNT = 8'h14; // count parameter
   localparam logic [7:0] OFS_SUBCMD = 8'h18; // subcommand code
   localparam logic [7:0] OFS_STATUS = 8'h1c; // drive status, read only
   localparam logic [7:0] OFS_ERROR = 8'h20; // error flags, read only
   localparam logic [7:0] OFS_MAXADDR = 8'h24; // current max address, read only
   localparam logic [7:0] OFS_BLKSIZE = 8'h28; // multiple block size, read only
   localparam logic [7:0] OFS_INTSTAT = 8'h2c; // sticky events, write one to clear
   localparam logic [7:0] OFS_INTMASK = 8'h30; // interrupt enables
   localparam logic [7:0] OFS_CTRL = 8'h34; // hw reset pulse, device number
   localparam logic [7:0] OFS_IDENT82 = 8'h38; // identify data word 82
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int DH_LBA = 6; // lba select in device/head
   localparam int DH_DEV = 4; // device select in device/head
   localparam int CNT_PERSIST = 0; // persistence_select_bit in count
   localparam int ST_BUSY = 0; // status bits
   localparam int ST_DRDY = 1;
   localparam int ST_ERR = 2;
   localparam int ST_SLEEP = 3;
   localparam int ST_MULT = 4;
   localparam int ST_LOCK = 5;
   localparam int ST_FROZEN = 6;
   localparam int ERR_ABORT = 2; // aborted-command flag
   localparam int EV_DONE = 0; // event bits
   localparam int EV_ABORT = 1;
   localparam int EV_SLEEP = 2;
   localparam int CTRL_HWRST = 0; // hardware reset, write one
   localparam int CTRL_DEVNUM = 1; // this drive's device number
   localparam int ID82_SMART = 0; // smart supported flag
   // ---------------------------------------------------------------
   // opcodes, subfunctions, limits, reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] OP_READ_NATIVE = 8'hf8;
   localparam logic [7:0] OP_SET_MAX = 8'hf9;
   localparam logic [7:0] OP_SET_MULT = 8'hc6;
   localparam logic [7:0] OP_SLEEP_A = 8'h99;
   localparam logic [7:0] OP_SLEEP_B = 8'he6;
   localparam logic [7:0] OP_STANDBY_A = 8'h96;
   localparam logic [7:0] OP_STANDBY_B = 8'he2;
   localparam logic [7:0] OP_SMART = 8'hb0;
   localparam logic [7:0] SMART_KEY = 8'hc2;
   localparam logic [7:0] SMF_OBSOLETE = 8'h00;
   localparam logic [7:0] SMF_PASSWORD = 8'h01;
   localparam logic [7:0] SMF_LOCK = 8'h02;
   localparam logic [7:0] SMF_UNLOCK = 8'h03;
   localparam logic [7:0] SMF_FREEZE = 8'h04;
   localparam logic [7:0] MAX_BLOCK = 8'h10; // largest supported block size
   localparam logic [27:0] NATIVE_MAX = 28'h0ffffff; // native capacity, plain default
   localparam logic [2:0] RST_IMASK = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0]
   {
      FSM_IDLE = 2'b01,
      FSM_EXEC = 2'b10
   } acb_fsm_type;
endpackage

//--- rtl/acb_cmd.sv
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
// Overview of operation
// R1: opcode F9h sets 28-bit max address
// R2: host sets lba bit for max address
// R3: only the selected device acts
// R4: max address needs ready and preceding F8h
// R5: count bit 0 selects persistence over reset
// R6: subcommand code selects max-address subfunction
// R7: abort repeated non-volatile set after reset
// R8: opcode C6h sets busy, reads count
// R9: valid block size stored, multiple enabled
// R10: unsupported block size aborts, disables multiple
// R11: zero block size disables without error
// R12: multiple disabled after power on
// R13: sleep/standby opcodes enter low power, interrupt
// R14: any later command wakes and executes
// R15: smart opcode B0h keyed by C2h dispatches
// R16: identify word 82 bit 0 shows smart
// R17: bad subfunction or order aborts, keeps max
module acb_cmd
   import acb_pkg::*;
(
   input wire logic aclk, // bus clock, 20 MHz
   input wire logic aresetn, // power-on reset, sync, low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   output logic irq, // level interrupt
   output logic smart_req, // one-cycle smart dispatch pulse
   output logic [7:0] smart_feature, // smart subfunction code
   output logic multiple_enable, // read/write multiple allowed
   output logic [7:0] multiple_block, // sectors per block
   output logic [27:0] max_address, // user-visible max address
   output logic low_power // low-power standby state
);
   // ---------------------------------------------------------------
   // state record
   // ---------------------------------------------------------------
   typedef struct packed {
      logic aw_full; // write address held
      logic [7:0] aw_addr;
      logic w_full; // write data held
      logic [31:0] w_data;
      logic w_lane0; // low byte enabled
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] cmd; // last opcode
      logic [7:0] devhead;
      logic [7:0] addr_hi;
      logic [7:0] addr_mid;
      logic [7:0] addr_lo;
      logic [7:0] count;
      logic [7:0] subcmd;
      acb_fsm_type fsm;
      logic busy;
      logic drdy;
      logic err;
      logic abort; // aborted-command flag
      logic sleep;
      logic mult_en;
      logic [7:0] blk;
      logic [27:0] max_addr;
      logic [27:0] nv_max; // last non-volatile setting
      logic native_ok; // previous command was good F8h
      logic nv_done; // non-volatile set since reset
      logic locked;
      logic frozen;
      logic dev_num;
      logic [2:0] ist;
      logic [2:0] imask;
      logic irq;
      logic smart_req;
      logic [7:0] smart_feat;
   } acb_state_type;
   acb_state_type st; // registered state
   acb_state_type next_st; // next state
   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb
   begin
      logic do_wr; // write commits this cycle
      logic [27:0] lba; // address assembled from task file
      logic bad; // command aborts
      logic [7:0] rd; // low byte of write data
      next_st = st;
      do_wr = 1'b0;
      lba = {st.devhead[3:0], st.addr_hi, st.addr_mid, st.addr_lo};
      bad = 1'b0;
      rd = st.w_data[7:0];
      next_st.smart_req = 1'b0; // pulse
      // capture write address and data in either order
      if (s_axi_awvalid && st.awready)
      begin
         next_st.aw_full = 1'b1;
         next_st.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st.wready)
      begin
         next_st.w_full = 1'b1;
         next_st.w_data = s_axi_wdata;
         next_st.w_lane0 = s_axi_wstrb[0];
      end
      if (st.bvalid && s_axi_bready)
         next_st.bvalid = 1'b0;
      // commit a write once both halves are held
      if (st.aw_full && st.w_full && !st.bvalid)
      begin
         do_wr = 1'b1;
         next_st.aw_full = 1'b0;
         next_st.w_full = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = RESP_OKAY;
      end
      if (do_wr)
      begin
         unique case (st.aw_addr)
            OFS_COMMAND:
               // busy drive or other device ignores the opcode
               if (st.w_lane0 && !st.busy && st.devhead[DH_DEV] == st.dev_num) // R3
               begin
                  next_st.cmd = rd;
                  next_st.busy = 1'b1; // R8
                  next_st.fsm = FSM_EXEC;
               end
            OFS_DEVHEAD:
               if (st.w_lane0 && !st.busy)
                  next_st.devhead = rd;
            OFS_ADDR_HI:
               if (st.w_lane0 && !st.busy)
                  next_st.addr_hi = rd;
            OFS_ADDR_MID:
               if (st.w_lane0 && !st.busy)
                  next_st.addr_mid = rd;
            OFS_ADDR_LO:
               if (st.w_lane0 && !st.busy)
                  next_st.addr_lo = rd;
            OFS_COUNT:
               if (st.w_lane0 && !st.busy)
                  next_st.count = rd;
            OFS_SUBCMD:
               if (st.w_lane0 && !st.busy)
                  next_st.subcmd = rd;
            OFS_INTSTAT:
               if (st.w_lane0)
                  next_st.ist = st.ist & ~rd[2:0];
            OFS_INTMASK:
               if (st.w_lane0)
                  next_st.imask = rd[2:0];
            OFS_CTRL:
               if (st.w_lane0)
               begin
                  next_st.dev_num = rd[CTRL_DEVNUM];
                  if (rd[CTRL_HWRST])
                  begin
                     // hardware reset: fall back to non-volatile max
                     next_st.max_addr = st.nv_max; // R5
                     next_st.nv_done = 1'b0; // R7
                     {next_st.native_ok, next_st.mult_en, next_st.locked, next_st.frozen,
                      next_st.sleep, next_st.busy, next_st.err, next_st.abort} = 8'h00;
                     next_st.fsm = FSM_IDLE;
                  end
               end
            OFS_STATUS, OFS_ERROR, OFS_MAXADDR, OFS_BLKSIZE, OFS_IDENT82:
               next_st.bresp = RESP_OKAY; // read-only, write ignored
            default:
               next_st.bresp = RESP_SLVERR; // unmapped
         endcase
      end
      // execute the latched command in one cycle
      if (st.fsm == FSM_EXEC && next_st.fsm == FSM_EXEC)
      begin
         next_st.fsm = FSM_IDLE;
         next_st.busy = 1'b0;
         next_st.sleep = 1'b0; // R14
         next_st.native_ok = 1'b0;
         case (st.cmd)
            OP_READ_NATIVE:
            begin
               // return native capacity in the task file
               {next_st.devhead[3:0], next_st.addr_hi, next_st.addr_mid,
                next_st.addr_lo} = NATIVE_MAX;
               next_st.native_ok = st.drdy;
            end
            OP_SET_MAX:
               case (st.subcmd) // R6
                  SMF_OBSOLETE:
                  begin
                     // plain set: needs ready, prior F8h, lba form, no lock
                     if (!st.drdy || !st.native_ok) // R4
                        bad = 1'b1; // R17
                     else if (!st.devhead[DH_LBA]) // R2
                        bad = 1'b1;
                     else if (st.locked || st.frozen)
                        bad = 1'b1;
                     else if (st.count[CNT_PERSIST] && st.nv_done) // R7
                        bad = 1'b1;
                     else
                     begin
                        next_st.max_addr = lba; // R1
                        if (st.count[CNT_PERSIST]) // R5
                        begin
                           next_st.nv_max = lba;
                           next_st.nv_done = 1'b1;
                        end
                     end
                  end
                  SMF_PASSWORD:
                     bad = st.frozen;
                  SMF_LOCK, SMF_UNLOCK:
                     if (st.frozen)
                        bad = 1'b1;
                     else
                        next_st.locked = (st.subcmd == SMF_LOCK);
                  SMF_FREEZE:
                     next_st.frozen = 1'b1;
                  default:
                     bad = 1'b1; // R17
               endcase
            OP_SET_MULT:
               if (st.count == 8'h00)
                  next_st.mult_en = 1'b0; // R11
               else if (st.count <= MAX_BLOCK && (st.count & (st.count - 8'h01)) == 8'h00)
               begin
                  next_st.blk = st.count; // R9
                  next_st.mult_en = 1'b1;
               end
               else
               begin
                  bad = 1'b1; // R10
                  next_st.mult_en = 1'b0;
               end
            OP_SLEEP_A, OP_SLEEP_B, OP_STANDBY_A, OP_STANDBY_B:
            begin
               next_st.sleep = 1'b1; // R13
               next_st.ist[EV_SLEEP] = 1'b1;
            end
            OP_SMART:
               if (st.addr_hi == SMART_KEY) // R15
               begin
                  next_st.smart_req = 1'b1;
                  next_st.smart_feat = st.subcmd;
               end
               else
                  bad = 1'b1;
            default:
               bad = 1'b1; // unsupported opcode
         endcase
         // completion sets events after any clear this cycle
         next_st.err = bad;
         next_st.abort = bad;
         next_st.ist[EV_DONE] = 1'b1; // R13
         next_st.ist[EV_ABORT] = next_st.ist[EV_ABORT] | bad;
      end
      // read channel
      if (st.rvalid && s_axi_rready)
         next_st.rvalid = 1'b0;
      if (s_axi_arvalid && st.arready)
      begin
         next_st.rvalid = 1'b1;
         next_st.rresp = RESP_OKAY;
         next_st.rdata = 32'h0000_0000;
         unique case (s_axi_araddr)
            OFS_COMMAND:
               next_st.rdata = 32'h0000_0000; // write only
            OFS_DEVHEAD:
               next_st.rdata[7:0] = st.devhead;
            OFS_ADDR_HI:
               next_st.rdata[7:0] = st.addr_hi;
            OFS_ADDR_MID:
               next_st.rdata[7:0] = st.addr_mid;
            OFS_ADDR_LO:
               next_st.rdata[7:0] = st.addr_lo;
            OFS_COUNT:
               next_st.rdata[7:0] = st.count;
            OFS_SUBCMD:
               next_st.rdata[7:0] = st.subcmd;
            OFS_STATUS:
               next_st.rdata[6:0] = {st.frozen, st.locked, st.mult_en, st.sleep, st.err,
                                     st.drdy, st.busy};
            OFS_ERROR:
               next_st.rdata[ERR_ABORT] = st.abort;
            OFS_MAXADDR:
               next_st.rdata[27:0] = st.max_addr;
            OFS_BLKSIZE:
               next_st.rdata[7:0] = st.blk;
            OFS_INTSTAT:
               next_st.rdata[2:0] = st.ist;
            OFS_INTMASK:
               next_st.rdata[2:0] = st.imask;
            OFS_CTRL:
               next_st.rdata[CTRL_DEVNUM] = st.dev_num;
            OFS_IDENT82:
               next_st.rdata[ID82_SMART] = 1'b1; // R16
            default:
               next_st.rresp = RESP_SLVERR; // unmapped
         endcase
      end
      // ready flags and interrupt registered from next values
      next_st.awready = !next_st.aw_full;
      next_st.wready = !next_st.w_full;
      next_st.arready = !next_st.rvalid;
      next_st.irq = |(next_st.ist & next_st.imask);
   end
   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st <= '0;
         st.awready <= 1'b1;
         st.wready <= 1'b1;
         st.arready <= 1'b1;
         st.fsm <= FSM_IDLE;
         st.drdy <= 1'b1;
         st.mult_en <= 1'b0; // R12
         st.max_addr <= NATIVE_MAX;
         st.nv_max <= NATIVE_MAX;
         st.imask <= RST_IMASK;
      end
      else
         st <= next_st;
   end
   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign s_axi_awready = st.awready;
   assign s_axi_wready = st.wready;
   assign s_axi_bvalid = st.bvalid;
   assign s_axi_bresp = st.bresp;
   assign s_axi_arready = st.arready;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;
   assign irq = st.irq;
   assign smart_req = st.smart_req;
   assign smart_feature = st.smart_feat;
   assign multiple_enable = st.mult_en;
   assign multiple_block = st.blk;
   assign max_address = st.max_addr;
   assign low_power = st.sleep;
endmodule

//--- dv/acb_cmd_sva.sv
`timescale 1ns/10ps
module acb_cmd_sva
   import acb_pkg::*;
(
   input logic aclk, // clock
   input logic aresetn, // sync reset, low
   input logic s_axi_awvalid, // aw valid
   input logic s_axi_awready, // aw ready
   input logic s_axi_wvalid, // w valid
   input logic s_axi_wready, // w ready
   input logic [1:0] s_axi_bresp, // b resp
   input logic s_axi_bvalid, // b valid
   input logic s_axi_bready, // b ready
   input logic s_axi_arvalid, // ar valid
   input logic s_axi_arready, // ar ready
   input logic [31:0] s_axi_rdata, // r data
   input logic s_axi_rvalid, // r valid
   input logic s_axi_rready, // r ready
   input logic irq, // interrupt
   input logic smart_req, // smart pulse
   input logic multiple_enable, // multiple on
   input logic [7:0] multiple_block, // block size
   input logic [27:0] max_address, // max address
   input logic low_power // standby
);
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ---------------------------------------------------------------
   // command results
   // ---------------------------------------------------------------
   property p_rst_val;
      $rose(aresetn) |-> max_address == NATIVE_MAX && !multiple_enable && !low_power && !irq;
   endproperty
   a_rst_val: assert property (p_rst_val) else $error("reset state wrong");
   property p_blk_legal;
      multiple_enable |-> multiple_block inside {8'h01, 8'h02, 8'h04, 8'h08, 8'h10};
   endproperty
   a_blk_legal: assert property (p_blk_legal) else $error("bad block size");
   property p_blk_chg;
      $changed(multiple_block) |-> multiple_enable;
   endproperty
   a_blk_chg: assert property (p_blk_chg) else $error("block stored while off");
   property p_max_src;
      $changed(max_address) |-> s_axi_bvalid || $past(s_axi_bvalid);
   endproperty
   a_max_src: assert property (p_max_src) else $error("max moved off a write");
   property p_smart_pulse;
      smart_req |=> !smart_req;
   endproperty
   a_smart_pulse: assert property (p_smart_pulse) else $error("smart pulse long");
   property p_wake;
      smart_req |-> !low_power;
   endproperty
   a_wake: assert property (p_wake) else $error("still asleep");
   // ---------------------------------------------------------------
   // bus handshakes
   // ---------------------------------------------------------------
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("b dropped");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("r dropped");
   property p_bans;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_bans: assert property (p_bans) else $error("no write answer");
   property p_rans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rans: assert property (p_rans) else $error("no read answer");
   c_smart: cover property (smart_req);
   c_sleep: cover property ($rose(low_power));
   c_mult: cover property ($rose(multiple_enable));
endmodule
bind acb_cmd acb_cmd_sva chk_u (.*);

//--- dv/acb_host.sv
`timescale 1ns/10ps
module acb_host
(
   input logic aclk, // clock
   output logic [7:0] s_axi_awaddr = 8'h00, // aw addr
   output logic s_axi_awvalid = 1'b0, // aw valid
   input logic s_axi_awready, // aw ready
   output logic [31:0] s_axi_wdata = 32'h0, // w data
   output logic [3:0] s_axi_wstrb = 4'h0, // w strobes
   output logic s_axi_wvalid = 1'b0, // w valid
   input logic s_axi_wready, // w ready
   input logic [1:0] s_axi_bresp, // b resp
   input logic s_axi_bvalid, // b valid
   output logic s_axi_bready = 1'b0, // b ready
   output logic [7:0] s_axi_araddr = 8'h00, // ar addr
   output logic s_axi_arvalid = 1'b0, // ar valid
   input logic s_axi_arready, // ar ready
   input logic [31:0] s_axi_rdata, // r data
   input logic [1:0] s_axi_rresp, // r resp
   input logic s_axi_rvalid, // r valid
   output logic s_axi_rready = 1'b0 // r ready
);
   // ---------------------------------------------------------------
   // write: both halves offered at once
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_ok = 1'b0;
      logic w_ok = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready)
         begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready)
         begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!s_axi_bvalid)
         @(posedge aclk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // ---------------------------------------------------------------
   // read: address, then data
   // ---------------------------------------------------------------
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      while (!s_axi_arready)
         @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      while (!s_axi_rvalid)
         @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule

//--- dv/acb_cmd_tb.sv
`timescale 1ns/10ps
module acb_cmd_tb;
   import acb_pkg::*;
   logic aclk = 1'b0; // 20 MHz clock
   logic aresetn = 1'b0; // sync reset
   logic [7:0] s_axi_awaddr, s_axi_araddr, smart_feature, multiple_block;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic irq, smart_req, multiple_enable, low_power;
   logic [27:0] max_address;
   logic [2:0] mask = 3'h0; // enables
   int fail_count = 0;
   int cmp_count = 0;
   int smart_seen = 0; // smart pulses
   always #25 aclk = ~aclk;
   acb_host host_u (.*);
   acb_cmd dut_u (.*);
   always @(posedge aclk)
      if (smart_req)
         smart_seen <= smart_seen + 1;
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      host_u.wr(a, {24'h0, d}, rs);
      chk(rs, RESP_OKAY);
   endtask
   task rd(input logic [7:0] a);
      host_u.rd(a, rv, rs);
      chk(rs, RESP_OKAY);
   endtask
   // command, then irq, events, clear
   task run(input logic [7:0] op, input logic [2:0] ev);
      wr(OFS_COMMAND, op);
      @(posedge aclk);
      chk(irq, |(ev & mask));
      rd(OFS_INTSTAT);
      chk(rv, ev);
      wr(OFS_INTSTAT, 8'h07);
   endtask
   // native read then set max
   task sm(input logic [7:0] dh, input logic [23:0] a, input logic [7:0] c, input logic [2:0] ev);
      run(OP_READ_NATIVE, 3'b001);
      wr(OFS_DEVHEAD, dh);
      wr(OFS_ADDR_HI, a[23:16]);
      wr(OFS_ADDR_MID, a[15:8]);
      wr(OFS_ADDR_LO, a[7:0]);
      wr(OFS_COUNT, c);
      wr(OFS_SUBCMD, SMF_OBSOLETE);
      run(OP_SET_MAX, ev);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task t_reset;
      rd(OFS_IDENT82);
      chk(rv[0], 1'b1);
      rd(OFS_MAXADDR);
      chk(rv, {4'h0, NATIVE_MAX});
      rd(OFS_BLKSIZE);
      chk(rv, 32'h0);
      chk(multiple_enable, 1'b0);
      rd(OFS_STATUS);
      chk(rv[1:0], 2'b10);
      host_u.rd(8'h3c, rv, rs);
      chk(rs, RESP_SLVERR);
      host_u.wr(8'h3c, 32'h1, rs);
      chk(rs, RESP_SLVERR);
      $display("t_reset done");
   endtask
   task t_mult;
      logic [7:0] sz [9];
      logic [0:8] ok; // expected enables
      sz = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h03, 8'h08, 8'h00, 8'h20};
      ok = 9'b111110100;
      mask = 3'h7;
      wr(OFS_INTMASK, 8'h07);
      foreach (sz[i])
      begin
         wr(OFS_COUNT, sz[i]);
         run(OP_SET_MULT, {1'b0, sz[i] != 0 && !ok[i], 1'b1});
         chk(multiple_enable, ok[i]);
         if (ok[i])
            chk(multiple_block, sz[i]);
      end
      $display("t_mult done");
   endtask
   task t_sleep;
      logic [7:0] op [4];
      op = '{OP_SLEEP_A, OP_SLEEP_B, OP_STANDBY_A, OP_STANDBY_B};
      foreach (op[i])
      begin
         run(op[i], 3'b101);
         chk(low_power, 1'b1);
      end
      wr(OFS_ADDR_HI, SMART_KEY);
      wr(OFS_SUBCMD, 8'hd8);
      run(OP_SMART, 3'b001);
      chk(low_power, 1'b0);
      chk(smart_feature, 8'hd8);
      chk(smart_seen, 1);
      wr(OFS_ADDR_HI, 8'h00);
      run(OP_SMART, 3'b011);
      wr(OFS_DEVHEAD, 8'h10);
      run(OP_SLEEP_A, 3'b000);
      chk(low_power, 1'b0);
      wr(OFS_DEVHEAD, 8'h00);
      mask = 3'h0;
      wr(OFS_INTMASK, 8'h00);
      run(OP_SLEEP_B, 3'b101);
      mask = 3'h7;
      wr(OFS_INTMASK, 8'h07);
      $display("t_sleep done");
   endtask
   task t_max;
      logic [7:0] sub [5];
      logic [2:0] ex [5];
      sub = '{8'h05, SMF_LOCK, SMF_UNLOCK, SMF_FREEZE, SMF_PASSWORD};
      ex = '{3'b011, 3'b001, 3'b001, 3'b001, 3'b011};
      run(OP_SET_MAX, 3'b011);
      rd(OFS_ERROR);
      chk(rv, 32'h4);
      chk(max_address, NATIVE_MAX);
      sm(8'h45, 24'h123456, 8'h00, 3'b001);
      chk(max_address, 28'h5123456);
      sm(8'h05, 24'h000100, 8'h00, 3'b011);
      chk(max_address, 28'h5123456);
      wr(OFS_CTRL, 8'h01);
      chk(max_address, NATIVE_MAX);
      sm(8'h41, 24'h001000, 8'h01, 3'b001);
      wr(OFS_CTRL, 8'h01);
      chk(max_address, 28'h1001000);
      sm(8'h42, 24'h000000, 8'h01, 3'b001);
      sm(8'h43, 24'h000000, 8'h01, 3'b011);
      chk(max_address, 28'h2000000);
      foreach (sub[i])
      begin
         wr(OFS_SUBCMD, sub[i]);
         run(OP_SET_MAX, ex[i]);
      end
      rd(OFS_STATUS);
      chk(rv[6], 1'b1);
      chk(max_address, 28'h2000000);
      $display("t_max done");
   endtask
   task wrap_up;
      $display("cmp=%0d fail=%0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_mult;
      t_sleep;
      t_max;
      wrap_up;
   end
   initial
   begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      wrap_up;
   end
endmodule
